// ==== hw/usb_rx_ep_pkg.sv ====
package usb_rx_ep_pkg;

    // register word offsets (byte addresses)
    localparam logic [7:0] OFF_EP_RX_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFF_DUAL_ROLE_CTRL_STATUS = 8'h04;
    localparam logic [7:0] OFF_EP_CONFIG = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_FIFO_LEVEL = 8'h14;

    // endpoint_rx_ctrl_status field positions
    localparam int POS_NO_RESPONSE = 18;
    localparam int POS_NO_ROOM = 17;
    localparam int POS_PKT_WAITING = 16;
    localparam int POS_REPEAT_LSB = 11;
    localparam int POS_LIMIT_LSB = 0;
    localparam int REPEAT_W = 5;
    localparam int LIMIT_W = 11;

    // dual_role_ctrl_status field position
    localparam int POS_SESSION = 0;

    // endpoint configuration field position and width
    localparam int POS_EP_TYPE = 0;
    localparam int EP_TYPE_W = 2;

    // interrupt status and mask bit positions
    localparam int IRQ_W = 3;
    localparam int IRQ_PKT = 0;
    localparam int IRQ_NODATA = 1;
    localparam int IRQ_OVERRUN = 2;

    // flag bank positions inside the endpoint
    localparam int FLAG_W = 3;
    localparam int FLAG_PKT = 0;
    localparam int FLAG_NODATA = 1;
    localparam int FLAG_OVERRUN = 2;

    // reset values
    localparam logic [REPEAT_W-1:0] RST_REPEAT = 5'h00;
    localparam logic [LIMIT_W-1:0] RST_LIMIT = 11'h000;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

    // failed receive attempts before the no-data error
    localparam logic [1:0] NODATA_TRIES = 2'h3;

    // transfer type of the receive endpoint
    typedef enum logic [EP_TYPE_W-1:0] {
        XFER_BULK = 2'h0,
        XFER_INTR = 2'h1,
        XFER_ISO = 2'h2,
        XFER_RSVD = 2'h3
    } xfer_t;

    // events from the link engine, one-cycle pulses
    typedef struct packed {
        logic pkt_in;   // a data packet arrived for the receive fifo
        logic pkt_pop;  // one packet was unloaded from the receive fifo
        logic no_data;  // host role: a receive attempt drew no data packet
    } link_evt_t;

    // session control outputs toward the port logic
    typedef struct packed {
        logic drive;       // a-device session is on
        logic srp;         // one-cycle session request start
        logic disconnect;  // one-cycle software disconnect
    } session_out_t;

endpackage

// ==== hw/sticky_flag_bank.sv ====
`timescale 1ns/1ps
// bank of sticky flags: hardware set wins over a clear in the same cycle
module sticky_flag_bank #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] flag_q; // stored flags
    logic [WIDTH-1:0] flag_d; // next flags

    // refuse an empty bank
    if (WIDTH < 1)
    begin : g_bad_width
        $error("sticky_flag_bank: WIDTH must be at least 1");
    end

    // clear first, then set, so a same-cycle event survives
    assign flag_d = (flag_q & ~clr) | set;
    assign q = flag_q;

    // flag storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

endmodule

// ==== hw/usb_rx_endpoint_status_session.sv ====
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Function
// - device role: isochronous fifo refusal sets overrun flag
// - overrun reads zero unless endpoint isochronous
// - host role: three empty non-isochronous tries set error
// - no-data error reads zero for isochronous
// - no-room flag high while fifo full
// - received packet sets waiting flag, interrupts
// - payload equals limit times repeat plus one
// - bulk splits one packet into repeat+1 packets
// - eleven-bit maximum receive payload field
// - b-device reads session, write one requests
// - b-device suspended: clearing session disconnects
module usb_rx_endpoint_status_session #(
    parameter int PKT_SLOTS = 2 // packet slots in the receive fifo
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire usb_rx_ep_pkg::link_evt_t LINK_EVT,
    input wire logic HOST_ROLE,
    input wire logic A_DEVICE,
    input wire logic SUSPENDED,
    input wire logic B_SESSION_ACTIVE,
    output logic RX_BUFFER_NO_ROOM,
    output logic RX_PACKET_WAITING,
    output logic [15:0] PAYLOAD_BYTES,
    output logic [5:0] SPLIT_COUNT,
    output usb_rx_ep_pkg::session_out_t SESSION_OUT,
    output logic IRQ
);

    localparam int CNT_W = $clog2(PKT_SLOTS + 1);
    localparam logic [CNT_W-1:0] SLOTS_FULL = CNT_W'(PKT_SLOTS);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // the slot count has to fit the fifo level register
    if (PKT_SLOTS < 1 || PKT_SLOTS > 255)
    begin : g_bad_slots
        $error("PKT_SLOTS must lie between 1 and 255");
    end

    // address decode
    wire sel_ctrl = REG_ADDR == usb_rx_ep_pkg::OFF_EP_RX_CTRL_STATUS;
    wire sel_role = REG_ADDR == usb_rx_ep_pkg::OFF_DUAL_ROLE_CTRL_STATUS;
    wire sel_cfg = REG_ADDR == usb_rx_ep_pkg::OFF_EP_CONFIG;
    wire sel_ists = REG_ADDR == usb_rx_ep_pkg::OFF_IRQ_STATUS;
    wire sel_imask = REG_ADDR == usb_rx_ep_pkg::OFF_IRQ_MASK;
    wire sel_level = REG_ADDR == usb_rx_ep_pkg::OFF_FIFO_LEVEL;

    // write strobes per register
    wire wr_ctrl = REG_WR && sel_ctrl;
    wire wr_role = REG_WR && sel_role;
    wire wr_cfg = REG_WR && sel_cfg;
    wire wr_ists = REG_WR && sel_ists;
    wire wr_imask = REG_WR && sel_imask;

    // software-steered state
    logic [usb_rx_ep_pkg::REPEAT_W-1:0] repeat_q; // payload_repeat_factor
    logic [usb_rx_ep_pkg::REPEAT_W-1:0] repeat_d;
    logic [usb_rx_ep_pkg::LIMIT_W-1:0] limit_q;   // rx_payload_limit
    logic [usb_rx_ep_pkg::LIMIT_W-1:0] limit_d;
    usb_rx_ep_pkg::xfer_t xfer_q;                 // endpoint transfer type
    usb_rx_ep_pkg::xfer_t xfer_d;
    logic [usb_rx_ep_pkg::IRQ_W-1:0] imask_q;     // interrupt mask
    logic [usb_rx_ep_pkg::IRQ_W-1:0] imask_d;
    logic session_q;                              // a-device session request
    logic session_d;

    // block state
    logic [CNT_W-1:0] level_q;  // packets held in the receive fifo
    logic [CNT_W-1:0] level_d;
    logic [1:0] tries_q;        // consecutive empty receive attempts
    logic [1:0] tries_d;
    logic srp_q;                // session request pulse
    logic disc_q;               // software disconnect pulse
    logic irq_q;                // registered interrupt level
    logic [31:0] rdata_q;       // read data, one cycle after the strobe
    logic [31:0] rdata_d;

    // flag banks
    logic [usb_rx_ep_pkg::FLAG_W-1:0] flag_set;
    logic [usb_rx_ep_pkg::FLAG_W-1:0] flag_clr;
    logic [usb_rx_ep_pkg::FLAG_W-1:0] flag_q;
    logic [usb_rx_ep_pkg::IRQ_W-1:0] ists_set;
    logic [usb_rx_ep_pkg::IRQ_W-1:0] ists_clr;
    logic [usb_rx_ep_pkg::IRQ_W-1:0] ists_q;

    // transfer type views; the reserved code behaves as bulk
    wire is_iso = xfer_q == usb_rx_ep_pkg::XFER_ISO;
    wire is_bulk_like = !is_iso;

    // fifo occupancy
    wire fifo_full = level_q == SLOTS_FULL;
    wire fifo_take = LINK_EVT.pkt_in && !fifo_full;
    wire fifo_pop = LINK_EVT.pkt_pop && (level_q != '0);

    // overrun: device role, packet refused, isochronous only
    wire ev_overrun = LINK_EVT.pkt_in && fifo_full && !HOST_ROLE && is_iso;

    // no-data: host role, bulk or interrupt, third empty attempt
    wire try_counts = LINK_EVT.no_data && HOST_ROLE && is_bulk_like;
    wire ev_nodata = try_counts && (tries_q == usb_rx_ep_pkg::NODATA_TRIES - 2'h1);

    // a data packet taken into the fifo
    wire ev_packet = fifo_take;

    // visible flag values
    wire show_overrun = flag_q[usb_rx_ep_pkg::FLAG_OVERRUN] && !HOST_ROLE && is_iso;
    wire show_nodata = flag_q[usb_rx_ep_pkg::FLAG_NODATA] && HOST_ROLE && is_bulk_like;
    wire show_shared = HOST_ROLE ? show_nodata : show_overrun;

    // fifo level bookkeeping
    always_comb
    begin
        level_d = level_q;
        if (fifo_take && !fifo_pop)
        begin
            level_d = level_q + CNT_ONE;
        end
        else if (fifo_pop && !fifo_take)
        begin
            level_d = level_q - CNT_ONE;
        end
    end

    // empty attempt counter, restarted by any data packet
    always_comb
    begin
        tries_d = tries_q;
        if (LINK_EVT.pkt_in)
        begin
            tries_d = 2'h0;
        end
        else if (ev_nodata)
        begin
            tries_d = 2'h0;
        end
        else if (try_counts)
        begin
            tries_d = tries_q + 2'h1;
        end
    end

    // hardware sets of the endpoint flags
    assign flag_set[usb_rx_ep_pkg::FLAG_PKT] = ev_packet;
    assign flag_set[usb_rx_ep_pkg::FLAG_NODATA] = ev_nodata;
    assign flag_set[usb_rx_ep_pkg::FLAG_OVERRUN] = ev_overrun;

    // a written zero clears, a written one leaves the flag alone
    assign flag_clr[usb_rx_ep_pkg::FLAG_PKT] =
        wr_ctrl && !REG_WDATA[usb_rx_ep_pkg::POS_PKT_WAITING];
    assign flag_clr[usb_rx_ep_pkg::FLAG_NODATA] =
        wr_ctrl && !REG_WDATA[usb_rx_ep_pkg::POS_NO_RESPONSE];
    assign flag_clr[usb_rx_ep_pkg::FLAG_OVERRUN] =
        wr_ctrl && !REG_WDATA[usb_rx_ep_pkg::POS_NO_RESPONSE];

    // endpoint status flags
    sticky_flag_bank #(
        .WIDTH(usb_rx_ep_pkg::FLAG_W)
    ) u_ep_flags (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    // interrupt events; status cleared by writing one
    assign ists_set[usb_rx_ep_pkg::IRQ_PKT] = ev_packet;
    assign ists_set[usb_rx_ep_pkg::IRQ_NODATA] = ev_nodata;
    assign ists_set[usb_rx_ep_pkg::IRQ_OVERRUN] = ev_overrun;
    assign ists_clr = wr_ists ? REG_WDATA[usb_rx_ep_pkg::IRQ_W-1:0] : '0;

    // interrupt status
    sticky_flag_bank #(
        .WIDTH(usb_rx_ep_pkg::IRQ_W)
    ) u_irq_flags (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .set(ists_set),
        .clr(ists_clr),
        .q(ists_q)
    );

    // control fields of the endpoint, configuration and mask registers
    assign repeat_d = wr_ctrl ?
        REG_WDATA[usb_rx_ep_pkg::POS_REPEAT_LSB +: usb_rx_ep_pkg::REPEAT_W] : repeat_q;
    assign limit_d = wr_ctrl ?
        REG_WDATA[usb_rx_ep_pkg::POS_LIMIT_LSB +: usb_rx_ep_pkg::LIMIT_W] : limit_q;
    assign xfer_d = wr_cfg ?
        usb_rx_ep_pkg::xfer_t'(REG_WDATA[usb_rx_ep_pkg::POS_EP_TYPE +:
        usb_rx_ep_pkg::EP_TYPE_W]) : xfer_q;
    assign imask_d = wr_imask ? REG_WDATA[usb_rx_ep_pkg::IRQ_W-1:0] : imask_q;

    // session bit: in a-device role the write is the session request
    wire wr_session = REG_WDATA[usb_rx_ep_pkg::POS_SESSION];
    assign session_d = (wr_role && A_DEVICE) ? wr_session : session_q;

    // b-device actions launched by the session write
    wire srp_d = wr_role && !A_DEVICE && wr_session;
    wire disc_d = wr_role && !A_DEVICE && !wr_session && SUSPENDED;

    // session bit as read back
    wire session_rd = A_DEVICE ? session_q : B_SESSION_ACTIVE;

    // read word of the endpoint register
    wire [31:0] ctrl_word = {13'h0000, show_shared, fifo_full,
        flag_q[usb_rx_ep_pkg::FLAG_PKT], repeat_q, limit_q};

    // read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (REG_RD)
        begin
            unique case (1'b1)
                sel_ctrl:
                begin
                    rdata_d = ctrl_word;
                end
                sel_role:
                begin
                    rdata_d[usb_rx_ep_pkg::POS_SESSION] = session_rd;
                end
                sel_cfg:
                begin
                    rdata_d[usb_rx_ep_pkg::POS_EP_TYPE +: usb_rx_ep_pkg::EP_TYPE_W] = xfer_q;
                end
                sel_ists:
                begin
                    rdata_d[usb_rx_ep_pkg::IRQ_W-1:0] = ists_q;
                end
                sel_imask:
                begin
                    rdata_d[usb_rx_ep_pkg::IRQ_W-1:0] = imask_q;
                end
                sel_level:
                begin
                    rdata_d[CNT_W-1:0] = level_q;
                end
                default:
                begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            repeat_q <= usb_rx_ep_pkg::RST_REPEAT;
            limit_q <= usb_rx_ep_pkg::RST_LIMIT;
            xfer_q <= usb_rx_ep_pkg::XFER_BULK;
            imask_q <= usb_rx_ep_pkg::RST_IRQ_MASK;
        end
        else
        begin
            repeat_q <= repeat_d;
            limit_q <= limit_d;
            xfer_q <= xfer_d;
            imask_q <= imask_d;
        end
    end

    // fifo level and attempt counter
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            level_q <= '0;
            tries_q <= 2'h0;
        end
        else
        begin
            level_q <= level_d;
            tries_q <= tries_d;
        end
    end

    // session state and its pulses
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            session_q <= 1'b0;
            srp_q <= 1'b0;
            disc_q <= 1'b0;
        end
        else
        begin
            session_q <= session_d;
            srp_q <= srp_d;
            disc_q <= disc_d;
        end
    end

    // read data and interrupt level
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            irq_q <= |(ists_q & imask_q);
        end
    end

    // payload per service interval: limit times (repeat + 1)
    wire [5:0] split_n = {1'b0, repeat_q} + 6'h01;
    wire [16:0] payload_full = limit_q * split_n;

    // outputs
    assign REG_RDATA = rdata_q;
    assign RX_BUFFER_NO_ROOM = fifo_full;
    assign RX_PACKET_WAITING = flag_q[usb_rx_ep_pkg::FLAG_PKT];
    assign PAYLOAD_BYTES = payload_full[15:0];
    assign SPLIT_COUNT = split_n;
    assign SESSION_OUT.drive = session_q && A_DEVICE;
    assign SESSION_OUT.srp = srp_q;
    assign SESSION_OUT.disconnect = disc_q;
    assign IRQ = irq_q;

endmodule

// ==== bench/usb_rx_ep_checker.sv ====
`timescale 1ns/1ps
// port-level checks of the receive status and session block
module usb_rx_ep_checker #(
    parameter int PKT_SLOTS = 2 // receive fifo slots of the watched block
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire usb_rx_ep_pkg::link_evt_t LINK_EVT,
    input wire logic A_DEVICE,
    input wire logic SUSPENDED,
    input wire logic RX_BUFFER_NO_ROOM,
    input wire logic RX_PACKET_WAITING,
    input wire logic [15:0] PAYLOAD_BYTES,
    input wire logic [5:0] SPLIT_COUNT,
    input wire usb_rx_ep_pkg::session_out_t SESSION_OUT,
    input wire logic IRQ
);
    // write decodes that the properties key on
    wire wr_ctl = REG_WR && (REG_ADDR == usb_rx_ep_pkg::OFF_EP_RX_CTRL_STATUS);
    wire wr_otg = REG_WR && (REG_ADDR == usb_rx_ep_pkg::OFF_DUAL_ROLE_CTRL_STATUS);
    wire wr_msk = REG_WR && (REG_ADDR == usb_rx_ep_pkg::OFF_IRQ_MASK);
    wire clr_wait = wr_ctl && !REG_WDATA[16]; // write zero to the waiting flag
    wire [10:0] w_lim = REG_WDATA[10:0]; // payload limit field of a write
    wire [4:0] w_rep = REG_WDATA[15:11]; // repeat field of a write
    wire w_s0 = REG_WDATA[0]; // session bit of a write
    wire evt_in = LINK_EVT.pkt_in; // packet arrival
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // b-device write of the session bit
    sequence s_b_wr;
        wr_otg && !A_DEVICE;
    endsequence
    property p_rd_idle;
        !$past(REG_RD) |-> (REG_RDATA == 32'h0000_0000);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data seen outside the read slot");
    property p_pkt_wait;
        evt_in && !RX_BUFFER_NO_ROOM |=> RX_PACKET_WAITING;
    endproperty
    a_pkt_wait: assert property (p_pkt_wait)
        else $error("packet arrival did not raise the waiting flag");
    // the fifo can only fill up on a packet arrival
    property p_room_rise;
        $rose(RX_BUFFER_NO_ROOM) |-> $past(evt_in);
    endproperty
    a_room_rise: assert property (p_room_rise)
        else $error("no-room flag rose without a packet arrival");
    property p_wait_fall;
        $fell(RX_PACKET_WAITING) |-> $past(clr_wait);
    endproperty
    a_wait_fall: assert property (p_wait_fall)
        else $error("waiting flag dropped without a zero write");
    property p_payload;
        wr_ctl |=> (PAYLOAD_BYTES == 16'($past(w_lim)) * (16'($past(w_rep)) + 16'h0001))
            && (SPLIT_COUNT == (6'($past(w_rep)) + 6'h01));
    endproperty
    a_payload: assert property (p_payload)
        else $error("payload size or split count wrong after a write");
    property p_srp;
        s_b_wr ##0 w_s0 |=> SESSION_OUT.srp;
    endproperty
    a_srp: assert property (p_srp)
        else $error("session request did not start");
    property p_disc;
        s_b_wr ##0 (!w_s0 && SUSPENDED) |=> SESSION_OUT.disconnect;
    endproperty
    a_disc: assert property (p_disc)
        else $error("suspended clear did not disconnect");
    property p_drive;
        wr_otg && A_DEVICE ##1 A_DEVICE |-> (SESSION_OUT.drive == $past(w_s0));
    endproperty
    a_drive: assert property (p_drive)
        else $error("a-device session does not follow the write");
    property p_mask;
        wr_msk && (REG_WDATA[2:0] == 3'h0) |-> ##2 !IRQ;
    endproperty
    a_mask: assert property (p_mask)
        else $error("interrupt high with all sources masked");
endmodule
bind usb_rx_endpoint_status_session usb_rx_ep_checker #(.PKT_SLOTS(PKT_SLOTS)) usb_rx_ep_checker_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LINK_EVT(LINK_EVT),
    .A_DEVICE(A_DEVICE), .SUSPENDED(SUSPENDED), .RX_BUFFER_NO_ROOM(RX_BUFFER_NO_ROOM),
    .RX_PACKET_WAITING(RX_PACKET_WAITING),
    .PAYLOAD_BYTES(PAYLOAD_BYTES), .SPLIT_COUNT(SPLIT_COUNT), .SESSION_OUT(SESSION_OUT),
    .IRQ(IRQ)
);

// ==== bench/usb_link_peer.sv ====
`timescale 1ns/1ps
// link-side peer: packets, unloads and empty receive attempts
module usb_link_peer (
    input wire logic clk,
    output usb_rx_ep_pkg::link_evt_t evt
);
    initial evt = '0;
    // one event per call; gap makes the peer slow to come back
    task automatic pulse(input usb_rx_ep_pkg::link_evt_t kind, input int gap);
        @(posedge clk);
        evt <= kind; // whole packets only
        @(posedge clk);
        evt <= '0;
        repeat (gap) @(posedge clk);
        #1;
    endtask
endmodule

// ==== bench/usb_rx_endpoint_status_session_tb_top.sv ====
`timescale 1ns/1ps
// self-checking bench of the receive status and session block
module usb_rx_endpoint_status_session_tb_top;
    logic clk_sys = 1'b0; // 20 MHz system clock
    logic rst_n = 1'b0; // active-low reset
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    usb_rx_ep_pkg::link_evt_t link_evt; // from the peer model
    logic host_role = 1'b0;
    logic a_device = 1'b0;
    logic suspended = 1'b0;
    logic b_session_active = 1'b0;
    logic no_room;
    logic pkt_waiting;
    logic [15:0] payload_bytes;
    logic [5:0] split_count;
    usb_rx_ep_pkg::session_out_t session_out;
    logic irq;
    logic [7:0] a_ctl, a_otg, a_cfg, a_ist, a_msk; // register addresses
    localparam logic [2:0] ev_pkt = 3'b100; // packet arrives
    localparam logic [2:0] ev_pop = 3'b010; // packet unloaded
    localparam logic [2:0] ev_nd = 3'b001; // empty receive attempt
    int n_mismatch = 0;
    int checks_done = 0;
    // clock: half period 25 ns
    always #25 clk_sys = ~clk_sys;
    usb_rx_endpoint_status_session #(.PKT_SLOTS(2)) usb_rx_endpoint_status_session_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINK_EVT(link_evt),
        .HOST_ROLE(host_role), .A_DEVICE(a_device), .SUSPENDED(suspended),
        .B_SESSION_ACTIVE(b_session_active), .RX_BUFFER_NO_ROOM(no_room),
        .RX_PACKET_WAITING(pkt_waiting), .PAYLOAD_BYTES(payload_bytes),
        .SPLIT_COUNT(split_count), .SESSION_OUT(session_out), .IRQ(irq)
    );
    usb_link_peer usb_link_peer_i (.clk(clk_sys), .evt(link_evt));
    // compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read, data judged in the slot after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // n link events, with a reply gap
    task automatic ev(input logic [2:0] k, input int n, input int gap);
        repeat (n) usb_link_peer_i.pulse(k, gap);
    endtask
    // reset values, unmapped place, ones written to flags
    task automatic t_reset();
        rc(a_ctl, 32'h0000_0000);
        rc(a_msk, 32'h0000_0000);
        chk(split_count, 32'h0000_0001);
        wr(8'hFC, 32'hFFFF_FFFF);
        rc(8'hFC, 32'h0000_0000);
        wr(a_ctl, 32'h0007_0000);
        rc(a_ctl, 32'h0000_0000);
    endtask
    // payload size and split count at field limits
    task automatic t_payload();
        logic [4:0] rep [4] = '{5'h00, 5'h1F, 5'h02, 5'h01}; // 2 for periodic
        logic [10:0] lim [4] = '{11'h7FF, 11'h7FF, 11'h400, 11'h006}; // two odd, two even
        for (int i = 0; i < 4; i++)
        begin
            wr(a_ctl, {16'h0000, rep[i], lim[i]});
            rc(a_ctl, {16'h0000, rep[i], lim[i]});
            chk(payload_bytes, 32'(lim[i]) * (32'(rep[i]) + 1));
            chk(split_count, 32'(rep[i]) + 1);
        end
        wr(a_ctl, 32'h0000_0000);
    endtask
    // packet waiting flag and its masked interrupt
    task automatic t_packet();
        wr(a_cfg, 32'h0000_0000);
        wr(a_msk, 32'h0000_0000);
        ev(ev_pkt, 1, 0);
        rc(a_ist, 32'h0000_0001);
        chk(irq, 32'h0000_0000);
        wr(a_msk, 32'h0000_0001);
        rc(a_ctl, 32'h0001_0000);
        chk(irq, 32'h0000_0001);
        wr(a_msk, 32'h0000_0000);
        rc(a_ist, 32'h0000_0001);
        chk(irq, 32'h0000_0000);
        wr(a_msk, 32'h0000_0001);
        wr(a_ctl, 32'h0001_0000);
        rc(a_ctl, 32'h0001_0000);
        ev(ev_pop, 1, 2); // software unloads first
        wr(a_ctl, 32'h0000_0000);
        chk(pkt_waiting, 32'h0000_0000);
        wr(a_ist, 32'h0000_0001);
        rc(a_ist, 32'h0000_0000);
        chk(irq, 32'h0000_0000);
    endtask
    // fifo full, refused packet, overrun per transfer type
    task automatic t_overrun();
        wr(a_cfg, 32'h0000_0002);
        ev(ev_pkt, 2, 0);
        chk(no_room, 32'h0000_0001);
        rc(usb_rx_ep_pkg::OFF_FIFO_LEVEL, 32'h0000_0002);
        rc(a_ctl, 32'h0003_0000);
        ev(ev_pkt, 1, 0);
        rc(a_ctl, 32'h0007_0000);
        for (int t = 0; t < 4; t++)
        begin
            wr(a_cfg, 32'(t));
            rc(a_cfg, 32'(t));
            rc(a_ctl, (t == 2) ? 32'h0007_0000 : 32'h0003_0000);
        end
        wr(a_cfg, 32'h0000_0002);
        wr(a_ctl, 32'h0001_0000);
        rc(a_ctl, 32'h0003_0000);
        rc(a_ist, 32'h0000_0005);
        ev(ev_pop, 1, 0);
        chk(no_room, 32'h0000_0000);
        ev(ev_pop, 1, 0);
        wr(a_ctl, 32'h0000_0000);
        wr(a_ist, 32'h0000_0007);
        rc(a_ctl, 32'h0000_0000);
    endtask
    // host role: three empty attempts in a row
    task automatic t_nodata();
        @(posedge clk_sys);
        host_role <= 1'b1;
        wr(a_cfg, 32'h0000_0000);
        ev(ev_nd, 2, 1);
        ev(ev_pkt, 1, 0);
        ev(ev_nd, 2, 2);
        rc(a_ctl, 32'h0001_0000);
        ev(ev_nd, 1, 0);
        rc(a_ctl, 32'h0005_0000);
        rc(a_ist, 32'h0000_0003);
        for (int t = 0; t < 4; t++)
        begin
            wr(a_cfg, 32'(t));
            rc(a_ctl, (t == 2) ? 32'h0001_0000 : 32'h0005_0000);
        end
        ev(ev_pop, 1, 0);
        wr(a_ctl, 32'h0000_0000);
        wr(a_ist, 32'h0000_0007);
        rc(a_ctl, 32'h0000_0000);
        host_role <= 1'b0;
    endtask
    // session bit as a-device and as b-device
    task automatic t_session();
        @(posedge clk_sys);
        a_device <= 1'b1;
        wr(a_otg, 32'h0000_0001);
        chk(session_out.drive, 32'h0000_0001);
        rc(a_otg, 32'h0000_0001);
        wr(a_otg, 32'h0000_0000);
        chk(session_out.drive, 32'h0000_0000);
        a_device <= 1'b0;
        b_session_active <= 1'b1;
        rc(a_otg, 32'h0000_0001);
        wr(a_otg, 32'h0000_0001);
        chk(session_out.srp, 32'h0000_0001);
        suspended <= 1'b1; // clear only in suspend
        wr(a_otg, 32'h0000_0000);
        chk(session_out.disconnect, 32'h0000_0001);
        b_session_active <= 1'b0;
        rc(a_otg, 32'h0000_0000);
    endtask
    // verdict and end of run
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        a_ctl = usb_rx_ep_pkg::OFF_EP_RX_CTRL_STATUS;
        a_otg = usb_rx_ep_pkg::OFF_DUAL_ROLE_CTRL_STATUS;
        a_cfg = usb_rx_ep_pkg::OFF_EP_CONFIG;
        a_ist = usb_rx_ep_pkg::OFF_IRQ_STATUS;
        a_msk = usb_rx_ep_pkg::OFF_IRQ_MASK;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_payload();
        t_packet();
        t_overrun();
        t_nodata();
        t_session();
        end_of_test();
    end
    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule
